// ### shared/io_assign_pkg.sv
// package for the servo drive control i/o assignment block
// assumes a single pclk domain and an apb master with 32-bit data
package io_assign_pkg;

  // pin counts and code widths
  localparam int IN_PINS       = 16;
  localparam int IN_LISTED     = 22;
  localparam int IN_FUNCS      = 28;              // code 0 plus 27 functions
  localparam int IN_CODE_W     = 5;
  localparam int OUT_PINS      = 7;
  localparam int OUT_LISTED    = 23;
  localparam int OUT_FUNCS     = 64;
  localparam int OUT_CODE_W    = 6;
  localparam int SEL_STRIDE    = 8;               // one select field per byte
  localparam int EVENTS        = 5;

  // register byte offsets
  localparam logic [7:0] IN_SEL0_OFS    = 8'h00;   // four regs 0x00..0x0C
  localparam logic [7:0] IN_POL_OFS     = 8'h10;
  localparam logic [7:0] OUT_SEL0_OFS   = 8'h14;   // two regs 0x14, 0x18
  localparam logic [7:0] OUT_CFG_OFS    = 8'h1C;
  localparam logic [7:0] PIN_STATE_OFS  = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h24;
  localparam logic [7:0] IRQ_CLEAR_OFS  = 8'h28;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h2C;

  // field positions
  localparam int ESTOP_POL_BIT  = 16;              // in IN_POL
  localparam int READY_NORM_BIT = 8;               // in OUT_CFG
  localparam int STATE_ESTOP    = 16;              // in PIN_STATE
  localparam int STATE_OUT_LSB  = 24;
  localparam int STATE_READY    = 31;

  // reset values
  localparam logic [31:0] SEL_RST   = 32'h0000_0000;   // all pins unassigned
  localparam logic [31:0] POL_RST   = 32'h0000_0000;
  localparam logic [31:0] IRQ_RST   = 32'h0000_0000;

  // interrupt event bits
  localparam int EV_ESTOP   = 0;
  localparam int EV_OT_PLUS = 1;
  localparam int EV_OT_MIN  = 2;
  localparam int EV_ALARM   = 3;
  localparam int EV_UNREADY = 4;

  // output function codes; 0 means unassigned
  localparam logic [5:0] OF_READY      = 6'h01;
  localparam logic [5:0] OF_WARNING    = 6'h02;
  localparam logic [5:0] OF_OT_PLUS    = 6'h03;
  localparam logic [5:0] OF_OT_MINUS   = 6'h04;
  localparam logic [5:0] OF_SERVO      = 6'h05;
  localparam logic [5:0] OF_BUSY       = 6'h06;
  localparam logic [5:0] OF_IN_POS     = 6'h07;
  localparam logic [5:0] OF_NEAR_A     = 6'h08;
  localparam logic [5:0] OF_NEAR_B     = 6'h09;
  localparam logic [5:0] OF_ZONE_LSB   = 6'h0A;     // zone a, b, c
  localparam logic [5:0] OF_OT_ANY     = 6'h0D;
  localparam logic [5:0] OF_NORMAL     = 6'h0E;
  localparam logic [5:0] OF_LEVEL_LSB  = 6'h0F;     // eight under/over flags
  localparam logic [5:0] OF_HOME_DONE  = 6'h17;
  localparam logic [5:0] OF_HOME_DEF   = 6'h18;
  localparam logic [5:0] OF_AUX_LSB    = 6'h20;     // sixteen other status lines

  // input function codes 1..22 are the listed inputs, then these
  localparam int IF_HOLD      = 23;
  localparam int IF_VEL_OVR   = 24;
  localparam int IF_INTEG_OFF = 25;
  localparam int IF_HOME_GO   = 26;
  localparam int IF_HOME_LIM  = 27;

  // internal drive status feeding the output pool
  typedef struct packed {
    logic        motor_ready;
    logic        alarm;
    logic        warning;
    logic        soft_ot_plus;
    logic        hard_ot_plus;
    logic        soft_ot_minus;
    logic        hard_ot_minus;
    logic        servo_on;
    logic        positioning;
    logic        pos_err_small;
    logic        near_a;
    logic        near_b;
    logic [2:0]  zone;
    logic [7:0]  levels;      // pos err, vel, torque, thermal under/over
    logic        home_done;
    logic        home_defined;
    logic [15:0] aux;
  } drive_status_type;

  // position feedback phases from the sensor interface
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
  } feedback_type;

endpackage

// ### hw/servo_drive_io_assignment.sv
// servo drive control i/o assignment: maps pins to functions under register control
// assumes synchronous pin inputs, one pclk domain, apb register access
//
// What this block does
// R1: ready output goes inactive when motor not ready or any alarm present.
// R2: separate plus and minus overtravel flags, each soft or hard limit.
// R3: in-position output combines small positioning error with idle positioning.
// R4: feedback a, b, index pulses each driven with a complementary line.
// R5: up to 16 input pins each select one of the listed input functions.
// R6: input pool also offers hold, velocity override, integration off, homing.
// R7: emergency stop sits on a fixed pin with selectable polarity.
// R8: up to 7 output pins each select one of the listed output functions.
// R9: output pool adds proximity b, zones, overtravel, normal, levels, homing.
// R10: ready pin may only switch to normal; its polarity is fixed.
// R11: one function per pin; unassigned outputs inactive, unassigned inputs ignored.
`timescale 1ns/10ps
module servo_drive_io_assignment
  import io_assign_pkg::*;
#(
  parameter int N_IN  = IN_PINS,
  parameter int N_OUT = OUT_PINS
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // control connector inputs
  input  wire logic                  emergency_stop_pin,
  input  wire logic [N_IN-1:0]       in_pin,
  // drive core side
  input  wire drive_status_type      status,
  input  wire feedback_type          feedback,
  output logic                       emergency_stop_in,
  output logic      [IN_FUNCS-1:0]   in_func,
  // control connector outputs
  output logic                       drive_ready_out,
  output logic      [N_OUT-1:0]      out_pin,
  output logic                       feedback_phase_a,
  output logic                       feedback_phase_a_n,
  output logic                       feedback_phase_b,
  output logic                       feedback_phase_b_n,
  output logic                       feedback_index,
  output logic                       feedback_index_n,
  // interrupt
  output logic                       irq
);

  // select field of one pin from a packed register image
  function automatic logic [7:0] sel_field(input logic [127:0] img, input int idx);
    sel_field = img[idx*SEL_STRIDE +: SEL_STRIDE];
  endfunction

  // configuration registers
  logic [127:0]          in_sel_reg;
  logic [IN_PINS-1:0]    in_pol_reg;
  logic                  estop_pol_reg;
  logic [63:0]           out_sel_reg;
  logic [OUT_PINS-1:0]   out_pol_reg;
  logic                  ready_norm_reg;
  logic [EVENTS-1:0]     irq_status_reg;
  logic [EVENTS-1:0]     irq_enable_reg;
  logic [EVENTS-1:0]     event_prev_reg;

  // bus decode
  logic                  setup_phase;
  logic                  wr_take;
  logic                  addr_ok;
  logic [31:0]           rd_next;
  logic [EVENTS-1:0]     event_now;
  logic [EVENTS-1:0]     event_rise;
  logic [EVENTS-1:0]     clear_mask;
  logic [OUT_FUNCS-1:0]  out_pool;
  logic [IN_FUNCS-1:0]   in_func_next;
  logic [N_OUT-1:0]      out_pin_next;
  logic                  ready_fn;
  logic                  normal_fn;
  logic                  ot_plus_fn;
  logic                  ot_minus_fn;
  logic                  in_pos_fn;
  logic                  estop_active;

  assign setup_phase = psel & ~penable;
  assign wr_take     = psel & penable & pready & pwrite;
  assign addr_ok     = (paddr[1:0] == 2'h0) && (paddr <= IRQ_ENABLE_OFS);

  // derived drive functions
  assign ready_fn    = status.motor_ready & ~status.alarm;                     // [R1]
  assign normal_fn   = ~status.alarm;
  assign ot_plus_fn  = status.soft_ot_plus | status.hard_ot_plus;              // [R2]
  assign ot_minus_fn = status.soft_ot_minus | status.hard_ot_minus;            // [R2]
  assign in_pos_fn   = status.pos_err_small & ~status.positioning;             // [R3]
  assign estop_active = emergency_stop_pin ^ estop_pol_reg;                    // [R7]

  // output function pool, code 0 stays low for unassigned pins
  always_comb begin
    out_pool = '0;
    out_pool[OF_READY]    = ready_fn;
    out_pool[OF_WARNING]  = status.warning;
    out_pool[OF_OT_PLUS]  = ot_plus_fn;
    out_pool[OF_OT_MINUS] = ot_minus_fn;
    out_pool[OF_SERVO]    = status.servo_on;
    out_pool[OF_BUSY]     = status.positioning;
    out_pool[OF_IN_POS]   = in_pos_fn;
    out_pool[OF_NEAR_A]   = status.near_a;
    out_pool[OF_NEAR_B]   = status.near_b;                                      // [R9]
    out_pool[OF_ZONE_LSB +: 3]  = status.zone;                                  // [R9]
    out_pool[OF_OT_ANY]   = ot_plus_fn | ot_minus_fn;                          // [R9]
    out_pool[OF_NORMAL]   = normal_fn;                                          // [R9]
    out_pool[OF_LEVEL_LSB +: 8] = status.levels;                                // [R9]
    out_pool[OF_HOME_DONE] = status.home_done;                                  // [R9]
    out_pool[OF_HOME_DEF]  = status.home_defined;                               // [R9]
    out_pool[OF_AUX_LSB +: 16]  = status.aux;                                   // [R8]
  end

  // output pins: each picks one code, unassigned code 0 stays low whatever its polarity bit
  always_comb begin
    out_pin_next = '0;
    for (int p = 0; p < N_OUT; p++) begin
      logic [7:0] code;
      code = sel_field({64'h0, out_sel_reg}, p);
      if (code[OUT_CODE_W-1:0] == '0) begin
        out_pin_next[p] = 1'b0;                                                 // [R11]
      end else begin
        out_pin_next[p] = out_pool[code[OUT_CODE_W-1:0]] ^ out_pol_reg[p];      // [R8]
      end
    end
  end

  // input functions: or of every pin that selects the code; code 0 ignored
  always_comb begin
    in_func_next = '0;
    for (int p = 0; p < N_IN; p++) begin
      logic [7:0] code;
      code = sel_field(in_sel_reg, p);
      if (code[IN_CODE_W-1:0] != '0 && int'(code[IN_CODE_W-1:0]) < IN_FUNCS) begin
        in_func_next[code[IN_CODE_W-1:0]] = in_func_next[code[IN_CODE_W-1:0]] |
                                            (in_pin[p] ^ in_pol_reg[p]);        // [R5] [R6]
      end
    end
    in_func_next[0] = 1'b0;                                                     // [R11]
  end

  // apb answer: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
      prdata  <= (setup_phase && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    case (paddr)
      8'h00, 8'h04, 8'h08, 8'h0C: rd_next = in_sel_reg[paddr[3:2]*32 +: 32];
      IN_POL_OFS:     rd_next = {15'h0, estop_pol_reg, in_pol_reg};
      OUT_SEL0_OFS:   rd_next = out_sel_reg[31:0];
      8'h18:          rd_next = out_sel_reg[63:32];
      OUT_CFG_OFS:    rd_next = {23'h0, ready_norm_reg, 1'b0, out_pol_reg};
      PIN_STATE_OFS:  rd_next = {drive_ready_out, out_pin, 7'h0, emergency_stop_in, in_func[16:1]};
      IRQ_STATUS_OFS: rd_next = {27'h0, irq_status_reg};
      IRQ_ENABLE_OFS: rd_next = {27'h0, irq_enable_reg};
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  // input select registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sel_reg <= {4{SEL_RST}};
    end else if (wr_take && !pslverr && paddr[7:4] == 4'h0) begin
      in_sel_reg[paddr[3:2]*32 +: 32] <= pwdata & 32'h1F1F_1F1F;   // five-bit codes
    end
  end

  // polarity and output select registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pol_reg     <= POL_RST[IN_PINS-1:0];
      estop_pol_reg  <= POL_RST[ESTOP_POL_BIT];
      out_sel_reg    <= {2{SEL_RST}};
      out_pol_reg    <= POL_RST[OUT_PINS-1:0];
      ready_norm_reg <= 1'b0;
    end else if (wr_take && !pslverr) begin
      case (paddr)
        IN_POL_OFS: begin
          in_pol_reg    <= pwdata[IN_PINS-1:0];
          estop_pol_reg <= pwdata[ESTOP_POL_BIT];                             // [R7]
        end
        OUT_SEL0_OFS: out_sel_reg[31:0]  <= pwdata & 32'h3F3F_3F3F;
        8'h18:        out_sel_reg[63:32] <= pwdata & 32'h003F_3F3F;   // pins 4..6
        OUT_CFG_OFS: begin
          out_pol_reg    <= pwdata[OUT_PINS-1:0];
          ready_norm_reg <= pwdata[READY_NORM_BIT];                           // [R10]
        end
        default: ;
      endcase
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= IRQ_RST[EVENTS-1:0];
    end else if (wr_take && !pslverr && paddr == IRQ_ENABLE_OFS) begin
      irq_enable_reg <= pwdata[EVENTS-1:0];
    end
  end

  // events: rising edges of emergency stop, overtravel, alarm, and ready loss
  assign event_now  = {~ready_fn, status.alarm, ot_minus_fn, ot_plus_fn, estop_active};
  assign event_rise = event_now & ~event_prev_reg;
  assign clear_mask = (wr_take && !pslverr && paddr == IRQ_CLEAR_OFS) ? pwdata[EVENTS-1:0] : '0;

  // sticky status, a new event beats a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_prev_reg <= IRQ_RST[EVENTS-1:0];
      irq_status_reg <= IRQ_RST[EVENTS-1:0];
    end else begin
      event_prev_reg <= event_now;
      irq_status_reg <= (irq_status_reg & ~clear_mask) | event_rise;
    end
  end

  // interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_reg & ~clear_mask) | event_rise) & irq_enable_reg);
    end
  end

  // fixed pins: emergency stop and ready, never reassigned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emergency_stop_in <= 1'b0;
      drive_ready_out   <= 1'b0;
    end else begin
      emergency_stop_in <= estop_active;                                       // [R7]
      drive_ready_out   <= ready_norm_reg ? normal_fn : ready_fn;              // [R1] [R10]
    end
  end

  // assignable pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin <= '0;
      in_func <= '0;
    end else begin
      out_pin <= out_pin_next;                                                  // [R8] [R11]
      in_func <= in_func_next;                                                  // [R5]
    end
  end

  // position feedback with complementary line driver pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feedback_phase_a   <= 1'b0;
      feedback_phase_a_n <= 1'b1;
      feedback_phase_b   <= 1'b0;
      feedback_phase_b_n <= 1'b1;
      feedback_index     <= 1'b0;
      feedback_index_n   <= 1'b1;
    end else begin
      feedback_phase_a   <= feedback.phase_a;                                   // [R4]
      feedback_phase_a_n <= ~feedback.phase_a;                                  // [R4]
      feedback_phase_b   <= feedback.phase_b;                                   // [R4]
      feedback_phase_b_n <= ~feedback.phase_b;                                  // [R4]
      feedback_index     <= feedback.index;                                     // [R4]
      feedback_index_n   <= ~feedback.index;                                    // [R4]
    end
  end

endmodule

// ### verification/drive_io_assertions.sv
// port checker for the control i/o assignment block
// assumes one pclk domain and an apb master on the register port
`timescale 1ns/10ps
module drive_io_checker
  import io_assign_pkg::*;
(
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // drive side and connector
  input wire drive_status_type status,
  input wire feedback_type     feedback,
  input wire logic             drive_ready_out,
  input wire logic             feedback_phase_a,
  input wire logic             feedback_phase_a_n,
  input wire logic             feedback_phase_b,
  input wire logic             feedback_phase_b_n,
  input wire logic             feedback_index,
  input wire logic             feedback_index_n,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus steps: setup, then a write of zero to the enables
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence mask_all_s;
    psel && penable && pready && pwrite && paddr == IRQ_ENABLE_OFS && pwdata == 32'h0000_0000;
  endsequence

  // bus handshake and interrupt masking
  setup_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
  irq_masked_a: assert property (mask_all_s |-> ##2 !irq) else $error("irq high with all enables off");
  // ready output and feedback lines
  ready_alarm_a: assert property (status.alarm |=> !drive_ready_out) else $error("ready during alarm");
  ready_rise_a: assert property ($rose(drive_ready_out) |-> $past(!status.alarm)) else $error("ready rose");
  fb_phase_a_a: assert property (1'b1 |=> feedback_phase_a == $past(feedback.phase_a)
    && feedback_phase_a_n != feedback_phase_a) else $error("phase a line wrong");
  fb_phase_bz_a: assert property (1'b1 |=> {feedback_phase_b, feedback_index}
    == $past({feedback.phase_b, feedback.index}) && feedback_phase_b_n != feedback_phase_b
    && feedback_index_n != feedback_index) else $error("phase b or index line wrong");
endmodule

bind servo_drive_io_assignment drive_io_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .status(status), .feedback(feedback), .drive_ready_out(drive_ready_out),
  .feedback_phase_a(feedback_phase_a), .feedback_phase_a_n(feedback_phase_a_n),
  .feedback_phase_b(feedback_phase_b), .feedback_phase_b_n(feedback_phase_b_n),
  .feedback_index(feedback_index), .feedback_index_n(feedback_index_n), .irq(irq));

// ### verification/host_io_model.sv
// host controller model: drives the connector input pins
// assumes the bench hands it the wanted levels, bit 16 is the stop line
`timescale 1ns/10ps
module host_io_model (
  // clock
  input  wire logic        pclk,
  // wanted levels
  input  wire logic [16:0] want,
  // connector pins
  output logic             emergency_stop_pin = 1'b0,
  output logic [15:0]      in_pin = 16'h0000
);
  // pins change right after an edge, like a synchronous controller
  always @(posedge pclk) begin
    {emergency_stop_pin, in_pin} <= want;
  end
endmodule

// ### verification/servo_drive_io_assignment_tb_top.sv
// self-checking bench for the control i/o assignment block
// assumes the package, the design, the host model and the checker are compiled first
`timescale 1ns/10ps
module servo_drive_io_assignment_tb_top import io_assign_pkg::*;;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, q, ocfg, ipol;
  logic             emergency_stop_pin, emergency_stop_in, drive_ready_out, irq, xr;
  logic [16:0]      host_want;
  logic [15:0]      in_pin;
  logic [27:0]      in_func, xf;
  logic [6:0]       out_pin, xo;
  logic [5:0]       fb_out;
  logic [7:0]       osel [8];
  logic [7:0]       isel [16];
  drive_status_type status;
  feedback_type     feedback;
  int               err_total, cmp_count;

  servo_drive_io_assignment dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emergency_stop_pin(emergency_stop_pin), .in_pin(in_pin), .status(status), .feedback(feedback),
    .emergency_stop_in(emergency_stop_in), .in_func(in_func), .drive_ready_out(drive_ready_out),
    .out_pin(out_pin), .feedback_phase_a(fb_out[5]), .feedback_phase_a_n(fb_out[4]),
    .feedback_phase_b(fb_out[3]), .feedback_phase_b_n(fb_out[2]), .feedback_index(fb_out[1]),
    .feedback_index_n(fb_out[0]), .irq(irq));
  host_io_model host_u (.pclk(pclk), .want(host_want), .emergency_stop_pin(emergency_stop_pin), .in_pin(in_pin));

  // 125 mhz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  // one apb transfer; waits for pready, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) err_total++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk("read data", q, x);
  endtask

  // reference for one output function code
  function automatic logic ofun(input int c);
    case (c)
      1: return status.motor_ready & ~status.alarm;
      2: return status.warning;
      3: return status.soft_ot_plus | status.hard_ot_plus;
      4: return status.soft_ot_minus | status.hard_ot_minus;
      5: return status.servo_on;
      6: return status.positioning;
      7: return status.pos_err_small & ~status.positioning;
      8: return status.near_a;
      9: return status.near_b;
      13: return status.soft_ot_plus | status.hard_ot_plus | status.soft_ot_minus | status.hard_ot_minus;
      14: return ~status.alarm;
      23: return status.home_done;
      24: return status.home_defined;
      default: begin
        if (c >= 10 && c <= 12) return status.zone[c-10];
        if (c >= 15 && c <= 22) return status.levels[c-15];
        if (c >= 32 && c <= 47) return status.aux[c-32];
        return 1'b0;
      end
    endcase
  endfunction

  // watchdog
  initial begin
    #160000;
    err_total++;
    close_out;
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, host_want} = '0;
    status = '0;
    feedback = '0;
    osel[7] = 8'h00;
    void'($urandom(36804));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // ready loss is already true at release, so its sticky bit comes up at the first edge
    for (int a = 0; a <= 44; a += 4) rd(8'(a), (8'(a) == IRQ_STATUS_OFS) ? 32'h0000_0010 : 32'h0000_0000);
    wr(PIN_STATE_OFS, 32'hFFFF_FFFF);
    wr(IRQ_STATUS_OFS, 32'hFFFF_FFFF);
    rd(PIN_STATE_OFS, 32'h0000_0000);
    rd(IRQ_STATUS_OFS, 32'h0000_0010);
    wr(IRQ_CLEAR_OFS, 32'h0000_001F);
    rd(IRQ_STATUS_OFS, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped error", 32'(e), 32'h1);
    apb(1'b1, 8'h01, 32'hFFFF_FFFF);
    chk("unaligned error", 32'(e), 32'h1);
    $display("test reset and map done");
    wr(IRQ_ENABLE_OFS, 32'h0000_001F);
    rd(IRQ_ENABLE_OFS, 32'h0000_001F);
    status.motor_ready <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("irq idle", 32'(irq), 32'h0);
    {status.alarm, status.hard_ot_plus, status.soft_ot_minus, host_want[16]} <= 4'hF;
    repeat (5) @(posedge pclk);
    chk("irq raised", 32'(irq), 32'h1);
    rd(IRQ_STATUS_OFS, 32'h0000_001F);
    wr(IRQ_ENABLE_OFS, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'(irq), 32'h0);
    wr(IRQ_CLEAR_OFS, 32'h0000_000F);
    rd(IRQ_STATUS_OFS, 32'h0000_0010);
    wr(IRQ_ENABLE_OFS, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    chk("irq ready loss", 32'(irq), 32'h1);
    wr(IRQ_CLEAR_OFS, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    rd(IRQ_STATUS_OFS, 32'h0000_0000);
    $display("test interrupt done");
    for (int r = 0; r < 20; r++) begin
      @(posedge pclk);
      host_want <= 17'($urandom);
      feedback <= feedback_type'($urandom);
      ipol = $urandom & 32'h0001_FFFF;
      for (int p = 0; p < 16; p++) isel[p] = 8'((r < 2) ? r * 16 + p : $urandom % 32);
      for (int k = 0; k < 4; k++) wr(8'(4 * k), {isel[4*k+3], isel[4*k+2], isel[4*k+1], isel[4*k]});
      wr(IN_POL_OFS, ipol);
      repeat (3) @(posedge pclk);
      xf = '0;
      for (int p = 0; p < 16; p++) if (isel[p] != 0 && isel[p] < 28) xf[isel[p]] |= host_want[p] ^ ipol[p];
      chk("in_func", 32'(in_func), 32'(xf));
      chk("emergency_stop_in", 32'(emergency_stop_in), 32'(host_want[16] ^ ipol[16]));
      chk("feedback", 32'(fb_out), 32'({feedback.phase_a, ~feedback.phase_a, feedback.phase_b,
        ~feedback.phase_b, feedback.index, ~feedback.index}));
    end
    $display("test input pool done");
    for (int r = 0; r < 40; r++) begin
      @(posedge pclk);
      status <= drive_status_type'({$urandom, $urandom});
      ocfg = $urandom & 32'h0000_01FF;
      for (int p = 0; p < 7; p++) osel[p] = 8'((r < 10) ? (r * 7 + p) % 64 : $urandom % 64);
      wr(OUT_SEL0_OFS, {osel[3], osel[2], osel[1], osel[0]});
      wr(OUT_SEL0_OFS + 8'h04, {osel[7], osel[6], osel[5], osel[4]});
      wr(OUT_CFG_OFS, ocfg);
      repeat (2) @(posedge pclk);
      // an unassigned pin stays low whatever its polarity bit
      for (int p = 0; p < 7; p++) xo[p] = (osel[p] == 8'h00) ? 1'b0 : ofun(osel[p]) ^ ocfg[p];
      xr = ocfg[8] ? ~status.alarm : status.motor_ready & ~status.alarm;
      chk("out_pin", 32'(out_pin), 32'(xo));
      chk("drive_ready_out", 32'(drive_ready_out), 32'(xr));
      apb(1'b0, PIN_STATE_OFS, 32'h0000_0000);
      chk("pin state outputs", 32'(q[31:24]), 32'({xr, xo}));
    end
    $display("test output pool done");
    close_out;
  end
endmodule
